// File: design/ccit_map.svh
// Register indices, field positions, reset values and counts of the clock block.
`ifndef CCIT_MAP_SVH
`define CCIT_MAP_SVH

// Register indices; byte address is four times the index.
`define CCIT_IDX_CPU_USB    10'h030
`define CCIT_IDX_TMR_CLK    10'h031
`define CCIT_IDX_CLK_IO     10'h032
`define CCIT_IDX_OSC_LOCK   10'h039
`define CCIT_IDX_OSC_CTL0   10'h1E0
`define CCIT_IDX_RELOAD_LO  10'h040
`define CCIT_IDX_RELOAD_HI  10'h041
`define CCIT_IDX_COUNT_LO   10'h042
`define CCIT_IDX_COUNT_HI   10'h043
`define CCIT_IDX_STATUS     10'h044

// Reset values.
`define CCIT_RST_OSC_CTL0   8'h00
`define CCIT_RST_TMR_CLK    8'h0C
`define CCIT_RST_CLK_IO     8'h00
`define CCIT_RST_OSC_LOCK   8'h00
`define CCIT_RST_RELOAD     12'h000

// Writable bit masks; everything else reads as zero.
`define CCIT_MSK_OSC_CTL0   8'h3F
`define CCIT_MSK_CLK_IO     8'h03
`define CCIT_MSK_OSC_LOCK   8'h03

// Field positions.
`define CCIT_F_CPU_SPEED    2:0
`define CCIT_F_SLEEP_SEL    4:3
`define CCIT_B_NO_BUZZ      5
`define CCIT_B_LOCK_OFF     0
`define CCIT_B_FINE_ONLY    1
`define CCIT_F_CAP_DIV      7:6
`define CCIT_F_CAP_SRC      5:4
`define CCIT_F_INT_DIV      3:2
`define CCIT_F_INT_SRC      1:0
`define CCIT_F_OUT_SEL      1:0

// Counts of slow oscillator ticks and of sleep timer overflows.
`define CCIT_RECOVER_TICKS  2'h3
`define CCIT_WDT_OVERFLOWS  2'h3

`endif

// File: design/ccit_pkg.sv
// Types shared by the clock configuration and interval timer block.
package ccit_pkg;

	// Processor clock availability around sleep.
	typedef enum logic [1:0] {
		CCIT_RUN,
		CCIT_SLEEP,
		CCIT_RECOVER
	} ccit_pwr_e;

	typedef logic [11:0] ccit_pit_t;
	typedef logic [7:0]  ccit_byte_t;

endpackage : ccit_pkg

// File: design/ccit_divider.sv
// Tick divider: one output pulse for every i_div input pulses.
`timescale 1ns/1ps
module ccit_divider #(
	parameter int W = 16
) (
	// Clock and reset.
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst_b,
	// Control.
	input  wire logic         i_clr,
	input  wire logic [W-1:0] i_div,
	// Ticks.
	input  wire logic         i_tick,
	output logic              o_tick
);

	logic [W-1:0] cnt_ff;
	logic         tick_ff;
	logic [W-1:0] last;

	// A divisor of zero behaves as one so the output never stalls.
	assign last = (i_div == '0) ? '0 : i_div - W'(1);

	// Counter restarts when the divisor shrinks below the count.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else if (i_clr) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= 1'b0;
			if (i_tick) begin
				if (cnt_ff >= last) begin
					cnt_ff  <= '0;
					tick_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + W'(1);
				end
			end
		end
	end

	assign o_tick = tick_ff;

endmodule : ccit_divider

// File: design/ccit_top.sv
// Clock configuration registers, clock dividers and the interval timer.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "ccit_map.svh"

module ccit_top (
	// Clock and reset.
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	// Wishbone slave.
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [11:0] i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic [31:0]      o_wb_dat,
	output logic             o_wb_ack,
	// Oscillator ticks and system state.
	input  wire logic        i_osc24_tick,
	input  wire logic        i_osc32_tick,
	input  wire logic        i_sleep,
	input  wire logic        i_duty_window,
	input  wire logic        i_usb_src_iosc,
	input  wire logic        i_wdt_enable,
	input  wire logic        i_wdt_clear,
	input  wire logic        i_sleep_timer_clear,
	// Derived ticks and controls.
	output logic             o_processor_clock,
	output logic             o_capture_timer_clock,
	output logic             o_interval_timer_clock,
	output logic             o_clock_output_pin,
	output logic             o_sleep_timer_tick,
	output logic             o_watchdog_reset,
	output logic             o_pit_irq,
	output logic             o_por_detect_en,
	output logic             o_osclock_en,
	output logic             o_coarse_tune_en
);

	// Register storage.
	ccit_pkg::ccit_byte_t osc_ctl0_ff;
	ccit_pkg::ccit_byte_t tmr_clk_ff;
	ccit_pkg::ccit_byte_t clk_io_ff;
	ccit_pkg::ccit_byte_t osc_lock_ff;
	ccit_pkg::ccit_pit_t  reload_ff;
	ccit_pkg::ccit_pit_t  pit_cnt_ff;
	logic                 ack_ff;
	logic [31:0]          rdat_ff;
	// Derived state.
	ccit_pkg::ccit_pwr_e  pwr_ff;
	logic [1:0]           rec_cnt_ff;
	logic [1:0]           wdt_cnt_ff;
	logic                 irq_ff, wdr_ff, por_en_ff;
	logic                 lock_en_ff, coarse_ff, clock_output_pin_ff;
	// Combinational nets.
	logic                 wr, rd_req;
	logic [9:0]           idx;
	logic [31:0]          nxt_rdat;
	logic                 cpu_in, cap_in, int_in;
	logic                 cpu_tick, cap_tick, int_tick, slp_tick;
	logic [7:0]           cpu_div;
	logic [3:0]           cap_div;
	logic [2:0]           int_div;
	logic [15:0]          slp_div;

	// Processor divisor from the speed code; reserved code stops the clock.
	function automatic logic [7:0] cpu_divisor(input logic [2:0] code);
		case (code)
			3'h0:    cpu_divisor = 8'h08;
			3'h1:    cpu_divisor = 8'h04;
			3'h2:    cpu_divisor = 8'h02;
			3'h3:    cpu_divisor = 8'h01;
			3'h4:    cpu_divisor = 8'h10;
			3'h5:    cpu_divisor = 8'h20;
			3'h6:    cpu_divisor = 8'h80;
			default: cpu_divisor = 8'h00;
		endcase
	endfunction : cpu_divisor

	// Slow oscillator division giving 512, 64, 8 or 1 Hz.
	function automatic logic [15:0] sleep_divisor(input logic [1:0] code);
		case (code)
			2'h0:    sleep_divisor = 16'h0040;
			2'h1:    sleep_divisor = 16'h0200;
			2'h2:    sleep_divisor = 16'h1000;
			default: sleep_divisor = 16'h8000;
		endcase
	endfunction : sleep_divisor

	// Bus decode: classic single cycle, one wait state, ack one cycle wide.
	assign idx    = i_wb_adr[11:2];
	assign rd_req = i_wb_cyc & i_wb_stb & ~ack_ff;
	assign wr     = rd_req & i_wb_we & i_wb_sel[0];

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else begin
			ack_ff  <= rd_req;
			rdat_ff <= nxt_rdat;
		end
	end

	// Read mux; unmapped indices and reserved bits return zero.
	always_comb begin
		nxt_rdat = 32'h0000_0000;
		case (idx)
			`CCIT_IDX_OSC_CTL0:  nxt_rdat[7:0] = osc_ctl0_ff;
			`CCIT_IDX_TMR_CLK:   nxt_rdat[7:0] = tmr_clk_ff;
			`CCIT_IDX_CLK_IO:    nxt_rdat[7:0] = clk_io_ff;
			`CCIT_IDX_OSC_LOCK:  nxt_rdat[7:0] = osc_lock_ff;
			`CCIT_IDX_RELOAD_LO: nxt_rdat[7:0] = reload_ff[7:0];
			`CCIT_IDX_RELOAD_HI: nxt_rdat[3:0] = reload_ff[11:8];
			`CCIT_IDX_COUNT_LO:  nxt_rdat[7:0] = pit_cnt_ff[7:0];
			`CCIT_IDX_COUNT_HI:  nxt_rdat[3:0] = pit_cnt_ff[11:8];
			`CCIT_IDX_STATUS:    nxt_rdat[3:0] = {pwr_ff == ccit_pkg::CCIT_RUN, i_sleep,
				wdt_cnt_ff};
			default:             nxt_rdat = 32'h0000_0000;
		endcase
	end
	assign o_wb_ack = ack_ff;
	assign o_wb_dat = rdat_ff;

	// Configuration writes; reserved bits are masked so they never steer clocks.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			osc_ctl0_ff <= `CCIT_RST_OSC_CTL0;
			tmr_clk_ff  <= `CCIT_RST_TMR_CLK;
			clk_io_ff   <= `CCIT_RST_CLK_IO;
			osc_lock_ff <= `CCIT_RST_OSC_LOCK;
		end else if (wr) begin
			case (idx)
				`CCIT_IDX_OSC_CTL0: osc_ctl0_ff <= i_wb_dat[7:0] & `CCIT_MSK_OSC_CTL0;
				`CCIT_IDX_TMR_CLK:  tmr_clk_ff  <= i_wb_dat[7:0];
				`CCIT_IDX_CLK_IO:   clk_io_ff   <= i_wb_dat[7:0] & `CCIT_MSK_CLK_IO;
				`CCIT_IDX_OSC_LOCK: osc_lock_ff <= i_wb_dat[7:0] & `CCIT_MSK_OSC_LOCK;
				default:            osc_lock_ff <= osc_lock_ff;
			endcase
		end
	end

	// Reload value is written a byte at a time, even while counting.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			reload_ff <= `CCIT_RST_RELOAD;
		end else if (wr && idx == `CCIT_IDX_RELOAD_LO) begin
			reload_ff[7:0] <= i_wb_dat[7:0];
		end else if (wr && idx == `CCIT_IDX_RELOAD_HI) begin
			reload_ff[11:8] <= i_wb_dat[3:0];
		end
	end

	// Processor clock stands still asleep and until the oscillator recovers.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_ff     <= ccit_pkg::CCIT_RUN;
			rec_cnt_ff <= 2'h0;
		end else begin
			case (pwr_ff)
				ccit_pkg::CCIT_RUN: begin
					if (i_sleep) begin
						pwr_ff <= ccit_pkg::CCIT_SLEEP;
					end
				end
				ccit_pkg::CCIT_SLEEP: begin
					rec_cnt_ff <= 2'h0;
					if (!i_sleep) begin
						pwr_ff <= ccit_pkg::CCIT_RECOVER;
					end
				end
				ccit_pkg::CCIT_RECOVER: begin
					if (i_osc32_tick) begin
						rec_cnt_ff <= rec_cnt_ff + 2'h1;
						if (rec_cnt_ff == `CCIT_RECOVER_TICKS - 2'h1) begin
							pwr_ff <= ccit_pkg::CCIT_RUN;
						end
					end
				end
				default: pwr_ff <= ccit_pkg::CCIT_RUN;
			endcase
		end
	end

	// Source selection; the slow oscillator feeds the capture and interval clocks only while awake.
	// The divider treats a zero divisor as one, so the reserved code is gated here.
	assign cpu_in = i_osc24_tick & (pwr_ff == ccit_pkg::CCIT_RUN) &
		(osc_ctl0_ff[`CCIT_F_CPU_SPEED] != 3'h7);
	assign cpu_div = cpu_divisor(osc_ctl0_ff[`CCIT_F_CPU_SPEED]);
	assign cap_in = (tmr_clk_ff[`CCIT_F_CAP_SRC] == 2'h0) ? i_osc24_tick :
		(tmr_clk_ff[`CCIT_F_CAP_SRC] == 2'h2) ? (i_osc32_tick & ~i_sleep) : 1'b0;
	assign cap_div = 4'({tmr_clk_ff[`CCIT_F_CAP_DIV], 1'b0}) + 4'h2;
	assign int_in = (tmr_clk_ff[`CCIT_F_INT_SRC] == 2'h0) ? i_osc24_tick :
		(tmr_clk_ff[`CCIT_F_INT_SRC] == 2'h2) ? (i_osc32_tick & ~i_sleep) :
		(tmr_clk_ff[`CCIT_F_INT_SRC] == 2'h3) ? cap_tick : 1'b0;
	assign int_div = {1'b0, tmr_clk_ff[`CCIT_F_INT_DIV]} + 3'h1;
	assign slp_div = sleep_divisor(osc_ctl0_ff[`CCIT_F_SLEEP_SEL]);

	// Processor clock divider.
	ccit_divider #(.W(8)) u_cpu_div (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_clr     (1'b0),
		.i_div     (cpu_div),
		.i_tick    (cpu_in),
		.o_tick    (cpu_tick)
	);

	// Capture clock divider.
	ccit_divider #(.W(4)) u_cap_div (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_clr     (1'b0),
		.i_div     (cap_div),
		.i_tick    (cap_in),
		.o_tick    (cap_tick)
	);

	// Interval clock prescaler.
	ccit_divider #(.W(3)) u_int_div (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_clr     (1'b0),
		.i_div     (int_div),
		.i_tick    (int_in),
		.o_tick    (int_tick)
	);

	// Sleep timer; an overflow is one output tick.
	ccit_divider #(.W(16)) u_slp_div (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_clr     (i_sleep_timer_clear),
		.i_div     (slp_div),
		.i_tick    (i_osc32_tick),
		.o_tick    (slp_tick)
	);
	assign o_processor_clock      = cpu_tick;
	assign o_capture_timer_clock  = cap_tick;
	assign o_interval_timer_clock = int_tick;
	assign o_sleep_timer_tick     = slp_tick;

	// Interval counter: the tick after zero is spent reloading.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pit_cnt_ff <= `CCIT_RST_RELOAD;
			irq_ff     <= 1'b0;
		end else begin
			irq_ff <= 1'b0;
			if (int_tick) begin
				if (pit_cnt_ff == 12'h000) begin
					pit_cnt_ff <= reload_ff;
					irq_ff     <= 1'b1;
				end else begin
					pit_cnt_ff <= pit_cnt_ff - 12'h001;
				end
			end
		end
	end
	assign o_pit_irq = irq_ff;

	// Watchdog counts sleep overflows; the third one resets the part.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wdt_cnt_ff <= 2'h0;
			wdr_ff     <= 1'b0;
		end else begin
			wdr_ff <= 1'b0;
			if (i_wdt_clear || !i_wdt_enable) begin
				wdt_cnt_ff <= 2'h0;
			end else if (slp_tick) begin
				if (wdt_cnt_ff == `CCIT_WDT_OVERFLOWS - 2'h1) begin
					wdt_cnt_ff <= 2'h0;
					wdr_ff     <= 1'b1;
				end else begin
					wdt_cnt_ff <= wdt_cnt_ff + 2'h1;
				end
			end
		end
	end
	assign o_watchdog_reset = wdr_ff;

	// Detector enable and oscillator lock controls, all registered.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			por_en_ff  <= 1'b1;
			lock_en_ff <= 1'b0;
			coarse_ff  <= 1'b0;
		end else begin
			// Duty window comes from its own trim, never from the sleep interval.
			por_en_ff  <= ~i_sleep | osc_ctl0_ff[`CCIT_B_NO_BUZZ] | i_duty_window;
			lock_en_ff <= ~osc_lock_ff[`CCIT_B_LOCK_OFF] & i_usb_src_iosc;
			coarse_ff  <= ~osc_lock_ff[`CCIT_B_LOCK_OFF] & i_usb_src_iosc &
				~osc_lock_ff[`CCIT_B_FINE_ONLY];
		end
	end
	assign o_por_detect_en  = por_en_ff;
	assign o_osclock_en     = lock_en_ff;
	assign o_coarse_tune_en = coarse_ff;

	// Clock output mirrors the selected source tick one cycle later.
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			clock_output_pin_ff <= 1'b0;
		end else begin
			case (clk_io_ff[`CCIT_F_OUT_SEL])
				2'h0:    clock_output_pin_ff <= i_osc24_tick;
				2'h2:    clock_output_pin_ff <= i_osc32_tick & ~i_sleep;
				2'h3:    clock_output_pin_ff <= cpu_tick;
				default: clock_output_pin_ff <= 1'b0;
			endcase
		end
	end
	assign o_clock_output_pin = clock_output_pin_ff;

	// Checks kept beside the logic.
	a_pit_reload_irq: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(int_tick && pit_cnt_ff == 12'h000) |=> (o_pit_irq && pit_cnt_ff == $past(reload_ff)))
		else $error("Interval counter did not reload with a request.");
	a_pit_count_down: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(int_tick && pit_cnt_ff != 12'h000) |=> pit_cnt_ff == $past(pit_cnt_ff) - 12'h001)
		else $error("Interval counter did not step down by one.");
	a_irq_on_reload: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_pit_irq |-> ($past(int_tick) && $past(pit_cnt_ff) == 12'h000))
		else $error("Interval request without a reload.");
	a_lock_gated: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_osclock_en |-> ($past(i_usb_src_iosc) && !$past(osc_lock_ff[0])))
		else $error("Oscillator lock active while disabled or not feeding USB.");
	a_fine_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_coarse_tune_en |-> (o_osclock_en && !$past(osc_lock_ff[1])))
		else $error("Coarse tuning while fine-only is set.");
	a_por_always: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_sleep && osc_ctl0_ff[5]) |=> o_por_detect_en)
		else $error("Detector off in sleep with continuous mode set.");
	a_wdt_third: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_watchdog_reset |-> ($past(slp_tick) && $past(wdt_cnt_ff) == 2'h2))
		else $error("Watchdog fired before the third overflow.");
	a_rsvd_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_wb_ack |-> (o_wb_dat[31:8] == 24'h00_0000 && osc_ctl0_ff[7:6] == 2'h0))
		else $error("Reserved bits read nonzero.");
	a_wake_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(pwr_ff == ccit_pkg::CCIT_SLEEP && !i_sleep) |=> (pwr_ff == ccit_pkg::CCIT_RECOVER)[*2])
		else $error("Processor clock resumed without recovery.");

endmodule : ccit_top

// File: bench/tb_clock_config_and_interval_timer.sv
// Self-checking testbench for the clock configuration and interval timer block.
`timescale 1ns/1ps
`include "ccit_map.svh"
module tb_clock_config_and_interval_timer;
	// Design ports, driven and watched by the bench.
	logic        i_clk_sys, i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we;
	logic [11:0] i_wb_adr;
	logic [3:0]  i_wb_sel;
	logic [31:0] i_wb_dat, o_wb_dat;
	logic        o_wb_ack, i_osc24_tick, i_osc32_tick, i_sleep, i_duty_window;
	logic        i_usb_src_iosc, i_wdt_enable, i_wdt_clear, i_sleep_timer_clear;
	logic        o_processor_clock, o_capture_timer_clock, o_interval_timer_clock;
	logic        o_clock_output_pin, o_sleep_timer_tick, o_watchdog_reset, o_pit_irq;
	logic        o_por_detect_en, o_osclock_en, o_coarse_tune_en;
	int          n_mismatch = 0;
	int          tests_run = 0;
	// Tick outputs gathered so that one measuring task serves them all.
	wire logic [5:0] probe = {o_sleep_timer_tick, o_clock_output_pin, o_pit_irq,
		o_interval_timer_clock, o_capture_timer_clock, o_processor_clock};

	ccit_top dut (
		.i_clk_sys, .i_rst_b, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
		.i_wb_dat, .o_wb_dat, .o_wb_ack, .i_osc24_tick, .i_osc32_tick, .i_sleep,
		.i_duty_window, .i_usb_src_iosc, .i_wdt_enable, .i_wdt_clear,
		.i_sleep_timer_clear, .o_processor_clock, .o_capture_timer_clock,
		.o_interval_timer_clock, .o_clock_output_pin, .o_sleep_timer_tick,
		.o_watchdog_reset, .o_pit_irq, .o_por_detect_en, .o_osclock_en, .o_coarse_tune_en
	);

	// System clock of 100 MHz.
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	// Verdict and end of the run.
	task automatic conclude();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	task automatic fail(input string what);
		n_mismatch++;
		$display("mismatch at %0t: %s", $time, what);
	endtask : fail

	// Compare tasks, one for each kind of result.
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) fail(what);
	endtask : chk_byte

	task automatic chk_int(input int got, input int exp, input string what);
		tests_run++;
		if (got != exp) fail(what);
	endtask : chk_int

	task automatic chk_bit(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) fail(what);
	endtask : chk_bit

	// One classic bus cycle; ack and read data are taken at the same edge.
	task automatic wb(input logic we, input logic [9:0] idx, input logic [7:0] wd,
		output logic [7:0] rdat);
		int n;
		@(posedge i_clk_sys);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we  <= we;
		i_wb_adr <= {idx, 2'b00};
		i_wb_dat <= {24'h00_0000, wd};
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 20);
		rdat = o_wb_dat[7:0];
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		if (o_wb_ack !== 1'b1) begin
			fail("bus answer missing");
			conclude();
		end
	endtask : wb

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [7:0] x;
		wb(1'b1, idx, d, x);
	endtask : wr

	task automatic rd(input logic [9:0] idx, output logic [7:0] d);
		wb(1'b0, idx, 8'h00, d);
	endtask : rd

	// Cycles up to the next pulse on one probe; a lost pulse ends the run.
	task automatic wait_pulse(input int k, output int n);
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (probe[k] !== 1'b1 && n < 40000);
		if (probe[k] !== 1'b1) begin
			fail("expected pulse never came");
			conclude();
		end
	endtask : wait_pulse

	// The third wait, the second whole gap, is taken, because the first may be cut short by a divisor change.
	task automatic period(input int k, output int p);
		wait_pulse(k, p);
		wait_pulse(k, p);
		wait_pulse(k, p);
	endtask : period

	// A few cycles pass first so that pulses already in flight can drain.
	task automatic quiet(input int k, input int cyc, input string what);
		int hits;
		hits = 0;
		repeat (3) @(posedge i_clk_sys);
		repeat (cyc) begin
			@(posedge i_clk_sys);
			if (probe[k] !== 1'b0) hits++;
		end
		chk_int(hits, 0, what);
	endtask : quiet

	task automatic t_reset();
		logic [7:0] v;
		rd(`CCIT_IDX_OSC_CTL0, v);
		chk_byte(v, 8'h00, "speed and sleep fields after reset");
		rd(`CCIT_IDX_TMR_CLK, v);
		chk_byte(v, 8'h0C, "timer clock config after reset");
		rd(`CCIT_IDX_CLK_IO, v);
		chk_byte(v, 8'h00, "clock output select after reset");
		rd(`CCIT_IDX_OSC_LOCK, v);
		chk_byte(v, 8'h00, "lock config after reset");
	endtask : t_reset

	task automatic t_reserved();
		logic [9:0] idx [5] = '{`CCIT_IDX_OSC_CTL0, `CCIT_IDX_CLK_IO, `CCIT_IDX_OSC_LOCK,
			`CCIT_IDX_CPU_USB, 10'h3FF};
		logic [7:0] exp [5] = '{8'h3F, 8'h03, 8'h03, 8'h00, 8'h00};
		logic [7:0] v;
		foreach (idx[i]) begin
			wr(idx[i], 8'hFF);
			rd(idx[i], v);
			chk_byte(v, exp[i], "reserved bits or unmapped place");
		end
	endtask : t_reserved

	task automatic t_cpu();
		int div [7] = '{8, 4, 2, 1, 16, 32, 128};
		int p;
		for (int c = 0; c < 7; c++) begin
			wr(`CCIT_IDX_OSC_CTL0, 8'(c));
			period(0, p);
			chk_int(p, div[c], "processor clock divisor");
		end
		wr(`CCIT_IDX_OSC_CTL0, 8'h07);
		quiet(0, 300, "reserved speed code must stop the clock");
	endtask : t_cpu

	task automatic t_timers();
		int p;
		for (int d = 0; d < 4; d++) begin
			wr(`CCIT_IDX_TMR_CLK, {d[1:0], 6'h00});
			period(1, p);
			chk_int(p, 2 * (d + 1), "capture divisor");
			wr(`CCIT_IDX_TMR_CLK, {4'h0, d[1:0], 2'b00});
			period(2, p);
			chk_int(p, d + 1, "interval divisor");
		end
		wr(`CCIT_IDX_TMR_CLK, 8'h47);
		period(2, p);
		chk_int(p, 8, "interval fed from capture clock");
		wr(`CCIT_IDX_TMR_CLK, 8'h30);
		quiet(1, 40, "capture clock disabled");
		wr(`CCIT_IDX_TMR_CLK, 8'h01);
		quiet(2, 40, "reserved interval source");
	endtask : t_timers

	task automatic t_pit();
		logic [7:0] v;
		int         p;
		wr(`CCIT_IDX_TMR_CLK, 8'h00);
		wr(`CCIT_IDX_RELOAD_HI, 8'h00);
		wr(`CCIT_IDX_RELOAD_LO, 8'h05);
		period(3, p);
		chk_int(p, 6, "reload of five gives six ticks per request");
		wr(`CCIT_IDX_RELOAD_HI, 8'hF1);
		rd(`CCIT_IDX_RELOAD_HI, v);
		chk_byte(v, 8'h01, "reload upper bits while counting");
		period(3, p);
		chk_int(p, 262, "request on each twelve-bit reload");
	endtask : t_pit

	task automatic t_sleep_timer();
		int p;
		int n;
		i_osc32_tick <= 1'b1;
		for (int c = 0; c < 3; c++) begin
			wr(`CCIT_IDX_OSC_CTL0, {3'b000, c[1:0], 3'b011});
			period(5, p);
			chk_int(p, 64 << (3 * c), "sleep timer divisor");
		end
		wr(`CCIT_IDX_OSC_CTL0, 8'h03);
		i_wdt_enable        <= 1'b1;
		i_wdt_clear         <= 1'b1;
		i_sleep_timer_clear <= 1'b1;
		@(posedge i_clk_sys);
		i_wdt_clear         <= 1'b0;
		i_sleep_timer_clear <= 1'b0;
		n = 0;
		while (o_watchdog_reset !== 1'b1 && n < 400) begin
			@(posedge i_clk_sys);
			n++;
		end
		chk_bit(n >= 188 && n <= 198, 1'b1, "watchdog after three overflows");
		if (n >= 400) conclude();
		i_wdt_enable <= 1'b0;
	endtask : t_sleep_timer

	task automatic t_detector();
		i_sleep       <= 1'b1;
		i_duty_window <= 1'b0;
		wr(`CCIT_IDX_OSC_CTL0, 8'h1B);
		repeat (2) @(posedge i_clk_sys);
		chk_bit(o_por_detect_en, 1'b0, "detector off outside its window");
		i_duty_window <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		chk_bit(o_por_detect_en, 1'b1, "detector follows its window");
		i_duty_window <= 1'b0;
		wr(`CCIT_IDX_OSC_CTL0, 8'h23);
		repeat (2) @(posedge i_clk_sys);
		chk_bit(o_por_detect_en, 1'b1, "detector held on");
	endtask : t_detector

	// Wake-up from sleep: the processor clock waits for three slow ticks.
	task automatic t_wake();
		int n;
		i_osc32_tick <= 1'b0;
		quiet(0, 50, "processor clock stopped in sleep");
		i_sleep <= 1'b0;
		quiet(0, 20, "processor clock waits for slow ticks");
		for (int c = 0; c < 3; c++) begin
			@(posedge i_clk_sys) i_osc32_tick <= 1'b1;
			@(posedge i_clk_sys) i_osc32_tick <= 1'b0;
			if (c < 2) quiet(0, 3, "processor clock waits for the third slow tick");
		end
		wait_pulse(0, n);
		chk_bit(n <= 8, 1'b1, "processor clock back after slow ticks");
	endtask : t_wake

	task automatic t_lock();
		i_usb_src_iosc <= 1'b1;
		wr(`CCIT_IDX_OSC_LOCK, 8'h00);
		@(posedge i_clk_sys);
		chk_bit(o_osclock_en, 1'b1, "lock enabled");
		chk_bit(o_coarse_tune_en, 1'b1, "coarse tuning allowed");
		wr(`CCIT_IDX_OSC_LOCK, 8'h02);
		@(posedge i_clk_sys);
		chk_bit(o_coarse_tune_en, 1'b0, "fine tuning only");
		wr(`CCIT_IDX_OSC_LOCK, 8'h01);
		@(posedge i_clk_sys);
		chk_bit(o_osclock_en, 1'b0, "lock disabled");
		wr(`CCIT_IDX_OSC_LOCK, 8'h00);
		i_usb_src_iosc <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		chk_bit(o_osclock_en, 1'b0, "lock idle with other usb source");
	endtask : t_lock

	task automatic t_clock_output_pin();
		int p;
		i_osc24_tick <= 1'b0;
		i_osc32_tick <= 1'b1;
		wr(`CCIT_IDX_CLK_IO, 8'h00);
		quiet(4, 30, "output follows the stopped fast source");
		wr(`CCIT_IDX_CLK_IO, 8'h02);
		period(4, p);
		chk_int(p, 1, "output follows the slow source");
		wr(`CCIT_IDX_CLK_IO, 8'h01);
		quiet(4, 30, "reserved output source");
		i_osc24_tick <= 1'b1;
		wr(`CCIT_IDX_OSC_CTL0, 8'h01);
		wr(`CCIT_IDX_CLK_IO, 8'h03);
		period(4, p);
		chk_int(p, 4, "output follows the processor clock");
	endtask : t_clock_output_pin

	// Main sequence: reset, then every scenario in turn.
	initial begin
		i_rst_b             = 1'b0;
		i_wb_cyc            = 1'b0;
		i_wb_stb            = 1'b0;
		i_wb_we             = 1'b0;
		i_wb_adr            = 12'h000;
		i_wb_sel            = 4'h1;
		i_wb_dat            = 32'h0000_0000;
		i_osc24_tick        = 1'b1;
		i_osc32_tick        = 1'b0;
		i_sleep             = 1'b0;
		i_duty_window       = 1'b0;
		i_usb_src_iosc      = 1'b0;
		i_wdt_enable        = 1'b0;
		i_wdt_clear         = 1'b0;
		i_sleep_timer_clear = 1'b0;
		repeat (4) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		t_reset();
		t_reserved();
		t_cpu();
		t_timers();
		t_pit();
		t_sleep_timer();
		t_detector();
		t_wake();
		t_lock();
		t_clock_output_pin();
		conclude();
	end
endmodule : tb_clock_config_and_interval_timer
